// [include/wdc_defines.svh]
// Register map, field positions, reset values and timing counts.
`ifndef WDC_DEFINES_SVH
`define WDC_DEFINES_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define WDC_ADDR_W 8
`define WDC_CTRL_ADDR 8'h00
`define WDC_CAUSE_ADDR 8'h01
`define WDC_CTRL_RST 8'h00
`define WDC_CAUSE_BIT 3

// ****************************************************************
// Timing
// ****************************************************************
`define WDC_CHANGE_CYCLES 3'h4
`define WDC_CNT_W 20
`define WDC_BASE_TICKS 21'h000800
`define WDC_SEL_MAX 4'h9

`endif

// [include/wdc_pkg.sv]
// Types shared by the watchdog control block.
package wdc_pkg;

  // Mode from {reset enable, interrupt enable}, Gray along the path
  typedef enum logic [1:0] {
    WDC_STOPPED = 2'h0,
    WDC_INTR = 2'h1,
    WDC_COMB = 2'h3,
    WDC_RESET = 2'h2
  } wdc_mode_e;

  // Control register layout, bit 7 first
  typedef struct packed {
    logic flag;
    logic irq_en;
    logic sel_hi;
    logic unlock;
    logic rst_en;
    logic [2:0] sel_lo;
  } wdc_ctrl_s;

endpackage

// [design/wdc_osc_sync.sv]
// Synchroniser and edge detector for the watchdog oscillator pin.
`timescale 1ns/1ps
`include "wdc_defines.svh"

module wdc_osc_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Oscillator pin and tick out
  input wire logic osc_pin,
  output logic osc_tick
);

  logic s1;
  logic s2;
  logic s3;
  logic lvl;
  logic agree;

  // Three stages; only the second reads the first
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= osc_pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // A change counts once stages two and three agree
  assign agree = (s2 == s3);

  // Accepted level, tick on each accepted rising edge
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lvl <= 1'b0;
      osc_tick <= 1'b0;
    end else begin
      lvl <= agree ? s3 : lvl;
      osc_tick <= agree & s3 & ~lvl;
    end
  end

endmodule

// [design/wdc_counter.sv]
// Time-out counter running on oscillator ticks.
`timescale 1ns/1ps
`include "wdc_defines.svh"

module wdc_counter (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Control
  input wire logic tick,
  input wire logic run,
  input wire logic restart,
  input wire logic [3:0] sel,
  // Event out
  output logic timeout
);

  logic [`WDC_CNT_W-1:0] cnt;
  logic [3:0] sel_c;
  logic [20:0] span;
  logic [`WDC_CNT_W-1:0] last;
  logic at_end;

  // Reserved codes act as the longest period
  assign sel_c = (sel > `WDC_SEL_MAX) ? `WDC_SEL_MAX : sel;
  assign span = `WDC_BASE_TICKS << sel_c;
  assign last = 20'(span - 21'h000001);
  assign at_end = (cnt == last);

  // Count ticks; restart or stop returns to zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt <= '0;
      timeout <= 1'b0;
    end else begin
      timeout <= run & tick & at_end & ~restart;
      if (restart | ~run) begin
        cnt <= '0;
      end else if (tick) begin
        cnt <= at_end ? '0 : cnt + 20'h00001;
      end
    end
  end

  // Restart always lands on zero
  property p_restart;
    @(posedge clk) disable iff (sys_rst) restart |=> cnt == '0;
  endproperty
  a_restart: assert property (p_restart)
    else $error("counter not zero after restart");

  // Time-out and a return to zero at the end of the selected tick count
  property p_span;
    @(posedge clk) disable iff (sys_rst)
      (run & tick & at_end & ~restart) |=> timeout && cnt == '0;
  endproperty
  a_span: assert property (p_span)
    else $error("time-out missed at period end");

endmodule

// [design/wdc_top.sv]
// Watchdog control: register, modes, timed unlock, reset cause.
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ps
`include "wdc_defines.svh"

// Overview of operation
// - Time-out in interrupt configuration sets flag
// - Vectoring to handler clears the flag
// - Writing one clears flag, zero ignored
// - Request needs flag, enable and global enable
// - Interrupt enable alone gives interrupt-only mode
// - Combined mode: first time-out interrupts only
// - Combined vector clears enable and flag
// - Unserviced flag at next time-out resets
// - Clock monitor forces reset mode, no interrupt; here only while any enable, fuse or cause flag is set
// - Clear reset enable or select needs unlock
// - Unlock bit self-clears after four clocks
// - Reset-cause flag holds reset enable set
// - Select code picks 2048 doubling ticks
// - Unlock write then change within four clocks
// - Always-on fuse forces reset-only mode
// - Watchdog reset sets cause flag; zero clears
// - Counter runs on separate oscillator ticks

module wdc_top (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [`WDC_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [7:0] reg_rdata,
  // Processor side
  input wire logic gie,
  input wire logic vector_ack,
  input wire logic wdr_restart,
  // Configuration levels
  input wire logic always_on_fuse,
  input wire logic clock_monitor,
  // Oscillator pin
  input wire logic wdt_osc,
  // Outputs
  output logic irq_req,
  output logic wdt_sys_reset
);

  // ****************************************************************
  // State
  // ****************************************************************
  logic timeout_flag;
  logic timeout_irq_enable;
  logic system_reset_enable;
  logic change_unlock;
  logic [3:0] timeout_select;
  logic [2:0] unlock_cnt;
  logic watchdog_reset_cause_flag;

  wdc_pkg::wdc_ctrl_s wr_f;
  wdc_pkg::wdc_ctrl_s rd_f;
  wdc_pkg::wdc_mode_e mode;
  logic ctrl_wr;
  logic cause_wr;
  logic any_en;
  logic eff_wde;
  logic eff_timeout_irq_enable;
  logic osc_tick;
  logic timeout;
  logic set_flag;
  logic clr_flag;
  logic fire_rst;
  logic comb_ack;
  logic wde_write;
  logic [7:0] rd_mux;

  // ****************************************************************
  // Decode
  // ****************************************************************

  // Address decode; writes land as a struct
  assign wr_f = reg_wdata;
  assign ctrl_wr = reg_we & (reg_addr == `WDC_CTRL_ADDR);
  assign cause_wr = reg_we & (reg_addr == `WDC_CAUSE_ADDR);

  // Effective enables; fuse and monitor override the stored bits
  assign any_en = always_on_fuse | system_reset_enable |
                  watchdog_reset_cause_flag | timeout_irq_enable;
  assign eff_wde = system_reset_enable | watchdog_reset_cause_flag |
                   always_on_fuse |
                   (clock_monitor & any_en);
  assign eff_timeout_irq_enable = timeout_irq_enable & ~always_on_fuse &
                    ~clock_monitor;
  assign mode = wdc_pkg::wdc_mode_e'({eff_wde, eff_timeout_irq_enable});

  // Time-out actions per mode
  assign set_flag = timeout & ((mode == wdc_pkg::WDC_INTR) |
                    ((mode == wdc_pkg::WDC_COMB) & ~timeout_flag));
  assign fire_rst = timeout & ((mode == wdc_pkg::WDC_RESET) |
                    ((mode == wdc_pkg::WDC_COMB) & timeout_flag));
  assign comb_ack = vector_ack & (mode == wdc_pkg::WDC_COMB);
  assign clr_flag = vector_ack | (ctrl_wr & wr_f.flag);

  // Ones always set the enable; a zero needs the open window
  assign wde_write = ctrl_wr & (wr_f.rst_en |
                     (change_unlock & ~watchdog_reset_cause_flag));

  // Request is a level while all three conditions hold
  assign irq_req = timeout_flag & eff_timeout_irq_enable & gie;

  // ****************************************************************
  // Submodules
  // ****************************************************************
  wdc_osc_sync u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .osc_pin(wdt_osc),
    .osc_tick(osc_tick)
  );

  // A fired reset starts the next period from zero
  wdc_counter u_cnt (
    .clk(clk),
    .sys_rst(sys_rst),
    .tick(osc_tick),
    .run(mode != wdc_pkg::WDC_STOPPED),
    .restart(wdr_restart | fire_rst),
    .sel(timeout_select),
    .timeout(timeout)
  );

  // ****************************************************************
  // Control register
  // ****************************************************************

  // Flag: a time-out in the clearing cycle wins
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      timeout_flag <= 1'b0;
    end else if (set_flag) begin
      timeout_flag <= 1'b1;
    end else if (clr_flag) begin
      timeout_flag <= 1'b0;
    end
  end

  // Interrupt enable: a software write wins over the fall-back
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      timeout_irq_enable <= 1'b0;
    end else if (ctrl_wr) begin
      timeout_irq_enable <= wr_f.irq_en;
    end else if (comb_ack) begin
      timeout_irq_enable <= 1'b0;
    end
  end

  // Reset enable and select; select only moves in the window
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      system_reset_enable <= 1'b0;
      timeout_select <= 4'h0;
    end else begin
      if (wde_write) begin
        system_reset_enable <= wr_f.rst_en;
      end
      if (ctrl_wr & change_unlock) begin
        timeout_select <= {wr_f.sel_hi, wr_f.sel_lo};
      end
    end
  end

  // Unlock window: four clocks, also closed by writing zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      change_unlock <= 1'b0;
      unlock_cnt <= 3'h0;
    end else if (ctrl_wr) begin
      change_unlock <= wr_f.unlock;
      unlock_cnt <= `WDC_CHANGE_CYCLES - 3'h1;
    end else if (unlock_cnt == 3'h0) begin
      change_unlock <= 1'b0;
    end else begin
      unlock_cnt <= unlock_cnt - 3'h1;
    end
  end

  // ****************************************************************
  // Reset cause and system reset
  // ****************************************************************

  // Cause flag set by a fired reset; sys_rst clears it like the rest
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      watchdog_reset_cause_flag <= 1'b0;
      wdt_sys_reset <= 1'b0;
    end else begin
      wdt_sys_reset <= fire_rst;
      if (fire_rst) begin
        watchdog_reset_cause_flag <= 1'b1;
      end else if (cause_wr & ~reg_wdata[`WDC_CAUSE_BIT]) begin
        watchdog_reset_cause_flag <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Read back
  // ****************************************************************

  // Enables read as they act, not as stored
  assign rd_f = '{flag: timeout_flag, irq_en: eff_timeout_irq_enable,
                  sel_hi: timeout_select[3], unlock: change_unlock,
                  rst_en: eff_wde, sel_lo: timeout_select[2:0]};
  assign rd_mux = (reg_addr == `WDC_CTRL_ADDR) ? rd_f :
                  (reg_addr == `WDC_CAUSE_ADDR) ?
                  8'(watchdog_reset_cause_flag) << `WDC_CAUSE_BIT :
                  8'h00;

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_re ? rd_mux : 8'h00;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  property p_irq_gate;
    irq_req |-> gie && timeout_flag && timeout_irq_enable;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt request without all enables");

  property p_intr_set;
    timeout && mode == wdc_pkg::WDC_INTR |=> timeout_flag && !wdt_sys_reset;
  endproperty
  a_intr_set: assert property (p_intr_set)
    else $error("interrupt mode time-out did not set flag");

  property p_ack_clear;
    vector_ack && !timeout |=> !timeout_flag;
  endproperty
  a_ack_clear: assert property (p_ack_clear)
    else $error("flag survived vectoring");

  property p_w1c;
    ctrl_wr && !reg_wdata[7] && !vector_ack |=>
      timeout_flag == $past(timeout_flag) || $past(set_flag);
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("writing zero changed the flag");

  property p_first_timeout;
    timeout && mode == wdc_pkg::WDC_COMB && !timeout_flag |=>
      timeout_flag && !wdt_sys_reset;
  endproperty
  a_first_timeout: assert property (p_first_timeout)
    else $error("combined mode reset on first time-out");

  property p_fallback;
    comb_ack && !ctrl_wr && !timeout |=>
      !timeout_irq_enable && !timeout_flag;
  endproperty
  a_fallback: assert property (p_fallback)
    else $error("combined vector did not fall back");

  property p_comb_reset;
    timeout && mode == wdc_pkg::WDC_COMB && timeout_flag |=>
      wdt_sys_reset && watchdog_reset_cause_flag;
  endproperty
  a_comb_reset: assert property (p_comb_reset)
    else $error("unserviced time-out gave no reset");

  property p_monitor;
    clock_monitor && any_en |-> mode == wdc_pkg::WDC_RESET && !irq_req;
  endproperty
  a_monitor: assert property (p_monitor)
    else $error("clock monitor not in reset mode");

  property p_locked;
    ctrl_wr && !change_unlock |=> $stable(timeout_select) &&
      (system_reset_enable || !$past(system_reset_enable));
  endproperty
  a_locked: assert property (p_locked)
    else $error("locked field changed without unlock");

  sequence s_open;
    ctrl_wr && reg_wdata[4];
  endsequence
  sequence s_quiet;
    !ctrl_wr [*4];
  endsequence
  property p_window;
    s_open ##1 s_quiet |=> !change_unlock;
  endproperty
  a_window: assert property (p_window)
    else $error("unlock window not closed after four clocks");

  property p_window_open;
    s_open ##1 !ctrl_wr [*3] |-> change_unlock;
  endproperty
  a_window_open: assert property (p_window_open)
    else $error("unlock window closed early");

  property p_cause_hold;
    watchdog_reset_cause_flag && ctrl_wr |=> eff_wde;
  endproperty
  a_cause_hold: assert property (p_cause_hold)
    else $error("reset enable cleared under cause flag");

  property p_fuse;
    always_on_fuse |-> mode == wdc_pkg::WDC_RESET;
  endproperty
  a_fuse: assert property (p_fuse)
    else $error("fuse did not force reset mode");

  property p_stopped;
    mode == wdc_pkg::WDC_STOPPED |=> !wdt_sys_reset && !set_flag;
  endproperty
  a_stopped: assert property (p_stopped)
    else $error("stopped watchdog acted");

endmodule

// [dv/tb_top.sv]
// Self-checking bench for the watchdog control block.
`timescale 1ns/1ps
`include "wdc_defines.svh"

module tb_top;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic clk;
  logic sys_rst;
  logic [`WDC_ADDR_W-1:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_we;
  logic reg_re;
  logic [7:0] reg_rdata;
  logic gie;
  logic vector_ack;
  logic wdr_restart;
  logic always_on_fuse;
  logic clock_monitor;
  logic wdt_osc;
  logic irq_req;
  logic wdt_sys_reset;
  int mismatches;
  int cmp_count;
  int rst_pulses;
  logic [3:0] code;
  logic [7:0] addr_r;

  // Device under test
  wdc_top u_dut (
    .clk(clk),
    .sys_rst(sys_rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_we(reg_we),
    .reg_re(reg_re),
    .reg_rdata(reg_rdata),
    .gie(gie),
    .vector_ack(vector_ack),
    .wdr_restart(wdr_restart),
    .always_on_fuse(always_on_fuse),
    .clock_monitor(clock_monitor),
    .wdt_osc(wdt_osc),
    .irq_req(irq_req),
    .wdt_sys_reset(wdt_sys_reset)
  );

  // 40 MHz system clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Reset pulses are one cycle wide, so count them as they pass
  always @(posedge clk) begin
    if (wdt_sys_reset === 1'b1) begin
      rst_pulses++;
    end
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %h expected %h",
               $time, what, got, exp);
    end
  endtask

  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Expected control value for a select code and reset enable
  function automatic logic [7:0] enc(input logic [3:0] s,
                                     input logic re);
    wdc_pkg::wdc_ctrl_s c;
    c = '0;
    c.sel_hi = s[3];
    c.sel_lo = s[2:0];
    c.rst_en = re;
    return c;
  endfunction

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    #1;
    chk(reg_rdata, exp, "read data");
  endtask

  // Timed unlock, then the real write gap idle cycles later
  task automatic unl(input logic [7:0] d, input int gap);
    wr(`WDC_CTRL_ADDR, 8'h18);
    idle(gap);
    wr(`WDC_CTRL_ADDR, d);
  endtask

  task automatic pulse(input bit ack);
    @(posedge clk);
    if (ack) begin
      vector_ack <= 1'b1;
    end else begin
      wdr_restart <= 1'b1;
    end
    @(posedge clk);
    vector_ack <= 1'b0;
    wdr_restart <= 1'b0;
  endtask

  // Each oscillator level held three clocks, past the synchroniser
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      wdt_osc <= 1'b1;
      repeat (3) @(posedge clk);
      wdt_osc <= 1'b0;
      repeat (2) @(posedge clk);
    end
    idle(6);
  endtask

  // Run limit: a hang ends in the same report
  initial begin
    repeat (95000) @(posedge clk);
    $display("CHECK FAILED at %0t: run limit reached", $time);
    mismatches++;
    test_done();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    sys_rst = 1'b1;
    reg_addr = '0;
    reg_wdata = '0;
    reg_we = 1'b0;
    reg_re = 1'b0;
    gie = 1'b0;
    vector_ack = 1'b0;
    wdr_restart = 1'b0;
    always_on_fuse = 1'b0;
    clock_monitor = 1'b0;
    wdt_osc = 1'b0;
    mismatches = 0;
    cmp_count = 0;
    rst_pulses = 0;
    void'($urandom(73));
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;

    // Reset values and an unmapped address
    addr_r = 8'($urandom_range(255, 2));
    wr(addr_r, 8'($urandom));
    rd(addr_r, 8'h00);
    rd(`WDC_CTRL_ADDR, `WDC_CTRL_RST);
    rd(`WDC_CAUSE_ADDR, 8'h00);
    $display("test reset_map done");

    // No enables: a full period passes without action
    ticks(2050);
    rd(`WDC_CTRL_ADDR, 8'h00);
    chk(8'(rst_pulses), 8'h00, "reset pulses");
    $display("test stopped done");

    // Interrupt mode, restart in mid-period, shortest select
    wr(`WDC_CTRL_ADDR, 8'h40);
    ticks(1000);
    pulse(1'b0);
    ticks(2047);
    rd(`WDC_CTRL_ADDR, 8'h40);
    ticks(1);
    rd(`WDC_CTRL_ADDR, 8'hc0);
    @(posedge clk);
    #1;
    chk(reg_rdata, 8'h00, "data after read slot");
    chk({7'h0, irq_req}, 8'h00, "irq without global");
    @(posedge clk);
    gie <= 1'b1;
    #1;
    chk({7'h0, irq_req}, 8'h01, "irq with global");
    wr(`WDC_CTRL_ADDR, 8'h40);
    rd(`WDC_CTRL_ADDR, 8'hc0);
    pulse(1'b1);
    rd(`WDC_CTRL_ADDR, 8'h40);
    chk({7'h0, irq_req}, 8'h00, "irq after vector");
    chk(8'(rst_pulses), 8'h00, "reset pulses");
    $display("test interrupt done");

    // Combined mode: interrupt first, reset when left unserviced
    wr(`WDC_CTRL_ADDR, 8'h48);
    pulse(1'b0);
    ticks(2048);
    rd(`WDC_CTRL_ADDR, 8'hc8);
    chk(8'(rst_pulses), 8'h00, "reset pulses");
    wr(`WDC_CTRL_ADDR, 8'hc8);
    rd(`WDC_CTRL_ADDR, 8'h48);
    pulse(1'b0);
    ticks(2048);
    pulse(1'b0);
    ticks(2048);
    chk(8'(rst_pulses), 8'h01, "reset pulses");
    rd(`WDC_CAUSE_ADDR, 8'h08);
    pulse(1'b1);
    rd(`WDC_CTRL_ADDR, 8'h08);
    chk({7'h0, irq_req}, 8'h00, "irq after fall-back");
    // Re-arm from outside the handler to stay in combined mode
    wr(`WDC_CTRL_ADDR, 8'h48);
    rd(`WDC_CTRL_ADDR, 8'h48);
    $display("test combined done");

    // Cause flag holds reset enable; timed unlock window
    wr(`WDC_CTRL_ADDR, 8'h00);
    rd(`WDC_CTRL_ADDR, 8'h08);
    unl(8'h00, 0);
    rd(`WDC_CTRL_ADDR, 8'h08);
    wr(`WDC_CAUSE_ADDR, 8'hff);
    rd(`WDC_CAUSE_ADDR, 8'h08);
    wr(`WDC_CAUSE_ADDR, 8'h00);
    rd(`WDC_CAUSE_ADDR, 8'h00);
    wr(`WDC_CTRL_ADDR, 8'h18);
    rd(`WDC_CTRL_ADDR, 8'h18);
    unl(8'h00, 3);
    rd(`WDC_CTRL_ADDR, 8'h08);
    unl(8'h00, 2);
    rd(`WDC_CTRL_ADDR, 8'h00);
    $display("test unlock done");

    // Fuse forces reset-only mode; clock monitor only while an enable is set
    wr(`WDC_CTRL_ADDR, 8'h40);
    @(posedge clk);
    always_on_fuse <= 1'b1;
    rd(`WDC_CTRL_ADDR, 8'h08);
    @(posedge clk);
    always_on_fuse <= 1'b0;
    clock_monitor <= 1'b1;
    rd(`WDC_CTRL_ADDR, 8'h08);
    wr(`WDC_CTRL_ADDR, 8'h00);
    rd(`WDC_CTRL_ADDR, 8'h00);
    @(posedge clk);
    clock_monitor <= 1'b0;
    $display("test fuse_monitor done");

    // Select codes change only through the unlock
    for (int i = 0; i < 4; i++) begin
      code = 4'($urandom_range(9));
      unl(enc(code, 1'b1), 0);
      rd(`WDC_CTRL_ADDR, enc(code, 1'b1));
      wr(`WDC_CTRL_ADDR, enc(code ^ 4'h1, 1'b1));
      rd(`WDC_CTRL_ADDR, enc(code, 1'b1));
    end
    $display("test select done");

    // Reset-only time-out records the cause; power-on reset clears it
    unl(enc(4'h0, 1'b1), 0);
    pulse(1'b0);
    ticks(2048);
    chk(8'(rst_pulses), 8'h02, "reset pulses");
    rd(`WDC_CAUSE_ADDR, 8'h08);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd(`WDC_CAUSE_ADDR, 8'h00);
    rd(`WDC_CTRL_ADDR, `WDC_CTRL_RST);
    $display("test mid_reset done");
    test_done();
  end
endmodule
